//--- src/ccpvs_top.sv
// Purpose: one capture/compare/pwm unit value path with apb registers
// Assumes: timer and 10-bit time base come from same-clock logic
// Notes:   value bytes reset to zero though documented as unknown
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module ccpvs_top
  import ccpvs_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           reset_in,
  input  wire logic           psel_in,
  input  wire logic           penable_in,
  input  wire logic           pwrite_in,
  input  wire logic [7:0]     paddr_in,
  input  wire logic [31:0]    pwdata_in,
  input  wire logic [3:0]     pstrb_in,
  output logic [31:0]         prdata_out,
  output logic                pready_out,
  output logic                pslverr_out,
  input  wire ccpvs_word_t    timer_in,
  input  wire logic [9:0]     time_base_in,
  input  wire logic           period_end_in,
  input  wire ccpvs_sources_t sources_in,
  input  wire logic           converter_src_sel_in,
  output logic                unit_out,
  output logic                timer_clear_out,
  output logic                converter_trigger_out,
  output logic                irq_out
);

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  logic [7:0]  ctrl;
  logic [2:0]  capture_trigger_select;
  logic [7:0]  ccp_value_low;
  logic [7:0]  ccp_value_high;
  logic [9:0]  duty_buf;
  logic [ccpvs_st_width-1:0] status;
  logic [ccpvs_st_width-1:0] mask;
  logic        unit_q;
  logic        trig_q;
  logic        trig_now;
  logic [3:0]  presc;
  logic        match_q;
  logic        pulse_q;

  logic        wr;
  logic        rd_ok;
  logic [3:0]  mode;
  logic        enabled;
  logic        fmt;
  ccpvs_class_t cls;
  logic        edge_hit;
  logic        cap_event;
  logic        cmp_match;
  logic        cmp_event;
  logic        pwm_clear;
  logic        unit_event;
  logic [9:0]  next_duty;
  logic        valid_addr;

  assign mode    = ctrl[3:0];
  assign enabled = ctrl[ccpvs_ctrl_en];
  assign fmt     = ctrl[ccpvs_ctrl_fmt];

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  always_comb begin
    unique case (mode)
      ccpvs_mode_off: cls = ccpvs_cls_off;
      ccpvs_mode_cap_any, ccpvs_mode_cap_fall, ccpvs_mode_cap_rise,
      ccpvs_mode_cap_r4, ccpvs_mode_cap_r16:
        cls = ccpvs_cls_capture;
      ccpvs_mode_cmp_tgcl, ccpvs_mode_cmp_tg, ccpvs_mode_cmp_set,
      ccpvs_mode_cmp_clr, ccpvs_mode_cmp_pls, ccpvs_mode_cmp_plcl:
        cls = ccpvs_cls_compare;
      default: cls = ccpvs_cls_pwm; // 1100..1111 all pwm
    endcase
  end

  // ------------------------------------------------------------
  // trigger source
  // ------------------------------------------------------------
  ccpvs_trigger_select u_sel (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .sources_in  (sources_in),
    .select_in   (capture_trigger_select),
    .trigger_out (trig_now)
  );

  always_ff @(posedge clk_in) begin
    if (reset_in)
      trig_q <= 1'b0;
    else
      trig_q <= trig_now;
  end

  // edge qualification per capture mode
  always_comb begin
    edge_hit = 1'b0;
    unique case (mode)
      ccpvs_mode_cap_any:  edge_hit = trig_now ^ trig_q;
      ccpvs_mode_cap_fall: edge_hit = trig_q & ~trig_now;
      default:             edge_hit = trig_now & ~trig_q;
    endcase
  end

  // prescaler for every 4th / 16th rising edge
  always_ff @(posedge clk_in) begin
    if (reset_in || !enabled || cls != ccpvs_cls_capture) begin
      presc <= 4'h0;
    end else if (edge_hit) begin
      presc <= presc + 4'h1;
      if ((mode == ccpvs_mode_cap_r4 && presc == ccpvs_presc_four) ||
          (mode == ccpvs_mode_cap_r16 && presc == ccpvs_presc_sixteen))
        presc <= 4'h0;
    end
  end

  always_comb begin
    cap_event = 1'b0;
    if (enabled && cls == ccpvs_cls_capture && edge_hit) begin
      unique case (mode)
        ccpvs_mode_cap_r4:  cap_event = (presc == ccpvs_presc_four);
        ccpvs_mode_cap_r16: cap_event = (presc == ccpvs_presc_sixteen);
        default:            cap_event = 1'b1;
      endcase
    end
  end

  // ------------------------------------------------------------
  // compare match
  // ------------------------------------------------------------
  assign cmp_match = (ccp_value_low == timer_in.low) &&
                     (ccp_value_high == timer_in.high);

  // event only on the first cycle of a match, timer may dwell
  always_ff @(posedge clk_in) begin
    if (reset_in)
      match_q <= 1'b0;
    else
      match_q <= cmp_match;
  end

  assign cmp_event = enabled && cls == ccpvs_cls_compare &&
                     cmp_match && !match_q;

  // ------------------------------------------------------------
  // pwm duty assembly and double buffer
  // ------------------------------------------------------------
  always_comb begin
    if (fmt)
      next_duty = {ccp_value_high, ccp_value_low[7:6]};
    else
      next_duty = {ccp_value_high[1:0], ccp_value_low};
  end

  always_ff @(posedge clk_in) begin
    if (reset_in)
      duty_buf <= 10'h000;
    else if (cls != ccpvs_cls_pwm || !enabled || period_end_in)
      duty_buf <= next_duty;
  end

  assign pwm_clear = enabled && cls == ccpvs_cls_pwm &&
                     time_base_in == duty_buf;

  assign unit_event = cap_event || cmp_event || pwm_clear;

  // ------------------------------------------------------------
  // unit output
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in || !enabled || cls == ccpvs_cls_off) begin
      unit_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= 1'b0;
      if (cls == ccpvs_cls_pwm) begin
        if (pwm_clear)
          unit_q <= 1'b0;
        else if (period_end_in && duty_buf != 10'h000)
          unit_q <= 1'b1;
      end else if (cmp_event) begin
        unique case (mode)
          ccpvs_mode_cmp_set: unit_q <= 1'b1;
          ccpvs_mode_cmp_clr: unit_q <= 1'b0;
          ccpvs_mode_cmp_pls, ccpvs_mode_cmp_plcl: begin
            unit_q  <= 1'b1;
            pulse_q <= 1'b1;
          end
          default: unit_q <= ~unit_q;
        endcase
      end else if (pulse_q) begin
        unit_q <= 1'b0;
      end
    end
  end

  assign unit_out = unit_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      timer_clear_out       <= 1'b0;
      converter_trigger_out <= 1'b0;
    end else begin
      timer_clear_out <= cmp_event && (mode == ccpvs_mode_cmp_tgcl ||
                                       mode == ccpvs_mode_cmp_plcl);
      converter_trigger_out <= unit_event && converter_src_sel_in;
    end
  end

  // ------------------------------------------------------------
  // apb slave, zero wait states
  // ------------------------------------------------------------
  assign wr = psel_in && penable_in && pwrite_in && pstrb_in[0];
  assign valid_addr = paddr_in == ccpvs_off_ctrl ||
                      paddr_in == ccpvs_off_cap ||
                      paddr_in == ccpvs_off_low ||
                      paddr_in == ccpvs_off_high ||
                      paddr_in == ccpvs_off_status ||
                      paddr_in == ccpvs_off_mask;
  assign rd_ok = valid_addr;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !rd_ok;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl <= ccpvs_ctrl_reset;
    end else if (wr && paddr_in == ccpvs_off_ctrl) begin
      ctrl <= pwdata_in[7:0] & ccpvs_ctrl_wmask;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in)
      capture_trigger_select <= ccpvs_cap_reset[2:0];
    else if (wr && paddr_in == ccpvs_off_cap)
      capture_trigger_select <= pwdata_in[2:0];
  end

  // capture wins over a software write in the same cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ccp_value_low  <= ccpvs_val_reset;
      ccp_value_high <= ccpvs_val_reset;
    end else if (cap_event) begin
      ccp_value_low  <= timer_in.low;
      ccp_value_high <= timer_in.high;
    end else if (wr) begin
      if (paddr_in == ccpvs_off_low)
        ccp_value_low <= pwdata_in[7:0];
      if (paddr_in == ccpvs_off_high)
        ccp_value_high <= pwdata_in[7:0];
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      status <= '0;
    end else begin
      if (wr && paddr_in == ccpvs_off_status)
        status[ccpvs_st_event] <= status[ccpvs_st_event] &
                                  ~pwdata_in[ccpvs_st_event];
      if (unit_event)
        status[ccpvs_st_event] <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in)
      mask <= '0;
    else if (wr && paddr_in == ccpvs_off_mask)
      mask <= pwdata_in[ccpvs_st_width-1:0];
  end

  assign irq_out = |(status & mask);

  always_comb begin
    prdata_out = 32'h0000_0000;
    unique case (paddr_in)
      ccpvs_off_ctrl: begin
        prdata_out[7:0] = ctrl;
        prdata_out[ccpvs_ctrl_out] = unit_q;
      end
      ccpvs_off_cap:    prdata_out[2:0] = capture_trigger_select;
      ccpvs_off_low:    prdata_out[7:0] = ccp_value_low;
      ccpvs_off_high:   prdata_out[7:0] = ccp_value_high;
      ccpvs_off_status: prdata_out[ccpvs_st_width-1:0] = status;
      ccpvs_off_mask:   prdata_out[ccpvs_st_width-1:0] = mask;
      default:          prdata_out = 32'h0000_0000;
    endcase
  end

endmodule

//--- shared/ccpvs_pkg.sv
// Purpose: constants and types for the capture/compare/pwm value block
// Assumes: apb slave with 32-bit data, one word per register
// Notes:   offsets below are byte addresses
//
// Contract
// - trigger selector: 000 pin, 001/010 comparators, 011 pin change, 1xx cells
// - selector bits 7..3 unimplemented, always read as zero
// - capture loads low value byte from timer low byte
// - capture loads high value byte from timer high byte
// - compare matches low value byte against timer low byte
// - compare matches high value byte against timer high byte
// - pwm right aligned: low byte gives eight low duty bits
// - pwm right aligned: high byte bits 1:0 give top duty bits
// - pwm left aligned: high byte gives eight top duty bits
// - pwm left aligned: low byte bits 7:6 give low duty bits
// - mode field selects off, capture edges, compare, pwm
// - every mode except off sets event flag and converter trigger when selected
// - pwm duty value double buffered, taken at period end
// - pwm output cleared when 10-bit time base equals buffered duty
package ccpvs_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ccpvs_off_ctrl   = 8'h00;
  localparam logic [7:0] ccpvs_off_cap    = 8'h04;
  localparam logic [7:0] ccpvs_off_low    = 8'h08;
  localparam logic [7:0] ccpvs_off_high   = 8'h0c;
  localparam logic [7:0] ccpvs_off_status = 8'h10;
  localparam logic [7:0] ccpvs_off_mask   = 8'h14;

  localparam logic [7:0] ccpvs_ctrl_reset = 8'h00;
  localparam logic [7:0] ccpvs_cap_reset  = 8'h00;
  localparam logic [7:0] ccpvs_val_reset  = 8'h00;

  // ctrl layout: enable 7, out 5 (ro), fmt 4, mode 3:0
  localparam int ccpvs_ctrl_en  = 7;
  localparam int ccpvs_ctrl_out = 5;
  localparam int ccpvs_ctrl_fmt = 4;
  localparam logic [7:0] ccpvs_ctrl_wmask = 8'h9f;

  // status/mask layout
  localparam int ccpvs_st_event = 0;
  localparam int ccpvs_st_width = 1;

  // ------------------------------------------------------------
  // mode and trigger codes
  // ------------------------------------------------------------
  localparam logic [3:0] ccpvs_mode_off      = 4'h0;
  localparam logic [3:0] ccpvs_mode_cmp_tgcl = 4'h1;
  localparam logic [3:0] ccpvs_mode_cmp_tg   = 4'h2;
  localparam logic [3:0] ccpvs_mode_cap_any  = 4'h3;
  localparam logic [3:0] ccpvs_mode_cap_fall = 4'h4;
  localparam logic [3:0] ccpvs_mode_cap_rise = 4'h5;
  localparam logic [3:0] ccpvs_mode_cap_r4   = 4'h6;
  localparam logic [3:0] ccpvs_mode_cap_r16  = 4'h7;
  localparam logic [3:0] ccpvs_mode_cmp_set  = 4'h8;
  localparam logic [3:0] ccpvs_mode_cmp_clr  = 4'h9;
  localparam logic [3:0] ccpvs_mode_cmp_pls  = 4'ha;
  localparam logic [3:0] ccpvs_mode_cmp_plcl = 4'hb;
  localparam logic [3:0] ccpvs_mode_pwm      = 4'hf;

  localparam logic [3:0] ccpvs_presc_four    = 4'h3;
  localparam logic [3:0] ccpvs_presc_sixteen = 4'hf;

  typedef enum logic [1:0] {
    ccpvs_cls_off,
    ccpvs_cls_capture,
    ccpvs_cls_compare,
    ccpvs_cls_pwm
  } ccpvs_class_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } ccpvs_word_t;

  typedef struct packed {
    logic       logic_cell_four_output;
    logic       logic_cell_three_output;
    logic       logic_cell_two_output;
    logic       logic_cell_one_output;
    logic       pin_change_event;
    logic       comparator_two_output;
    logic       comparator_one_output;
    logic       unit1_input_pin_route;
  } ccpvs_sources_t;

endpackage

//--- src/ccpvs_trigger_select.sv
// Purpose: synchronise trigger sources and pick one by selector code
// Assumes: sources are asynchronous to clk_in
// Notes:   output is the synchronised level, not an edge
`timescale 1ns/1ps
module ccpvs_trigger_select
  import ccpvs_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           reset_in,
  input  wire ccpvs_sources_t sources_in,
  input  wire logic [2:0]     select_in,
  output logic                trigger_out
);

  logic [7:0] sync_a;
  logic [7:0] sync_b;

  // ------------------------------------------------------------
  // two-stage synchroniser per source
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_sync
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          sync_a[i] <= 1'b0;
          sync_b[i] <= 1'b0;
        end else begin
          sync_a[i] <= sources_in[i];
          sync_b[i] <= sync_a[i];
        end
      end
    end
  endgenerate

  // struct bit order matches selector codes 000..111
  always_comb begin
    trigger_out = sync_b[select_in];
  end

endmodule

//--- test/ccpvs_top_monitor.sv
// Purpose: port checker for the capture/compare/pwm value block
// Assumes: shadows only software writes to ctrl and the value bytes
// Notes:   captures are not shadowed, so match checks need written values
`timescale 1ns/1ps
module ccpvs_top_monitor
  import ccpvs_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire ccpvs_word_t timer_in,
  input wire logic [9:0]  time_base_in,
  input wire logic        period_end_in,
  input wire logic        converter_src_sel_in,
  input wire logic        unit_out,
  input wire logic        timer_clear_out,
  input wire logic        converter_trigger_out
);
  // ------------------------------------------------------------
  // shadow of written registers
  // ------------------------------------------------------------
  logic [7:0] ctrl_s, low_s, high_s;
  logic [9:0] duty_s;
  logic       acc, wr_go, pwm_on, mapped, match, cmp8, clr_hit, mode_off;
  assign acc      = psel_in & penable_in;
  assign wr_go    = acc & pwrite_in & pstrb_in[0] & pready_out;
  assign pwm_on   = ctrl_s[7] & (ctrl_s[3:2] == 2'b11);
  assign mapped   = (paddr_in[1:0] == 2'b00) & (paddr_in <= ccpvs_off_mask);
  assign match    = (timer_in == {high_s, low_s});
  assign cmp8     = ctrl_s[7] & (ctrl_s[3:0] == ccpvs_mode_cmp_set);
  assign mode_off = (ctrl_s[3:0] == ccpvs_mode_off);
  assign clr_hit  = ctrl_s[7] & match & ((ctrl_s[3:0] == 4'h1)
                    | (ctrl_s[3:0] == ccpvs_mode_cmp_plcl));
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_s <= 8'h00;
      low_s  <= 8'h00;
      high_s <= 8'h00;
    end else if (wr_go) begin
      if (paddr_in == ccpvs_off_ctrl) ctrl_s <= pwdata_in[7:0];
      if (paddr_in == ccpvs_off_low) low_s <= pwdata_in[7:0];
      if (paddr_in == ccpvs_off_high) high_s <= pwdata_in[7:0];
    end
  end
  // duty follows the bytes until pwm runs, then only at period end
  always_ff @(posedge clk_in) begin
    if (reset_in) duty_s <= 10'h000;
    else if (period_end_in | ~pwm_on)
      duty_s <= ctrl_s[ccpvs_ctrl_fmt] ? {high_s, low_s[7:6]}
                                       : {high_s[1:0], low_s};
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  ready_high_a: assert property (psel_in |-> pready_out)
    else $error("pready low during a transfer");
  slverr_map_a: assert property (acc |-> pslverr_out == !mapped)
    else $error("slave error does not match the address map");
  upper_zero_a: assert property (acc & !pwrite_in |->
    prdata_out[31:8] == 24'h0 && (mapped || prdata_out == 32'h0))
    else $error("read data has stray bits");
  sel_bits_a: assert property (
    acc & !pwrite_in & (paddr_in == ccpvs_off_cap) |-> prdata_out[7:3] == 5'h0)
    else $error("selector upper bits read nonzero");
  pwm_clear_a: assert property (
    pwm_on && time_base_in == duty_s |=> !unit_out)
    else $error("pwm output not cleared at duty match");
  cmp_match_a: assert property (
    cmp8 && $rose(unit_out) |-> $past(match) || $past(match, 2))
    else $error("compare output set without a full match");
  timer_clear_a: assert property (
    $rose(timer_clear_out) |-> $past(clr_hit) || $past(clr_hit, 2))
    else $error("timer clear outside a clearing compare match");
  off_idle_a: assert property (mode_off [*2] |-> !unit_out)
    else $error("unit output active while off");
  conv_cmp_a: assert property (cmp8 && $rose(unit_out) |->
    converter_trigger_out == $past(converter_src_sel_in))
    else $error("no converter trigger on a compare event");
  conv_src_a: assert property (
    converter_trigger_out |-> $past(converter_src_sel_in) && $past(ctrl_s[7]))
    else $error("converter trigger without selection");
endmodule
bind ccpvs_top ccpvs_top_monitor i_ccpvs_top_monitor (
  .clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
  .timer_in, .time_base_in, .period_end_in, .converter_src_sel_in,
  .unit_out, .timer_clear_out, .converter_trigger_out
);

//--- test/ccpvs_timer_model.sv
// Purpose: 16-bit timer and 10-bit pwm time base beside the unit
// Assumes: same clock as the unit
// Notes:   timer only counts when told, so captures see a known value
`timescale 1ns/1ps
module ccpvs_timer_model
  import ccpvs_pkg::*;
#(
  parameter int period_cycles = 40
)
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        run_in,
  input  wire logic        load_in,
  input  wire ccpvs_word_t value_in,
  input  wire logic        timer_clear_in,
  output ccpvs_word_t      timer_out,
  output logic [9:0]       time_base_out,
  output logic             period_end_out
);
  // ------------------------------------------------------------
  // counters
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in | timer_clear_in) timer_out <= 16'h0000;
    else if (load_in) timer_out <= value_in;
    else if (run_in) timer_out <= timer_out + 16'h0001;
  end
  always_ff @(posedge clk_in) begin
    if (reset_in | period_end_out) time_base_out <= 10'h000;
    else time_base_out <= time_base_out + 10'h001;
  end
  assign period_end_out = (time_base_out == 10'(period_cycles - 1));
endmodule

//--- test/ccpvs_top_bench.sv
// Purpose: self-checking bench for the capture/compare/pwm value block
// Assumes: zero-wait apb slave, timer model on the same clock
// Notes:   value bytes are seen only through register reads
`timescale 1ns/1ps
module ccpvs_top_bench
  import ccpvs_pkg::*;
;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] n;
  } ccpvs_row_t;
  localparam int per = 40;
  logic        clk_in, reset_in, psel_in, penable_in, pwrite_in, run, load;
  logic        period_end_in, converter_src_sel_in, unit_out, irq_out;
  logic        pready_out, pslverr_out, timer_clear_out, converter_trigger_out;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd_v;
  logic [3:0]  pstrb_in;
  logic [9:0]  time_base_in;
  ccpvs_word_t    timer_in, load_val;
  ccpvs_sources_t sources_in;
  int          miscompares, checks_done, cycles, n, k, c, conv_n;
  ccpvs_row_t  rows [9] = '{
    '{ccpvs_off_cap, 8'hff, 8'h07, 0}, '{ccpvs_off_cap, 8'h05, 8'h05, 0},
    '{ccpvs_off_low, 8'ha5, 8'ha5, 0}, '{ccpvs_off_high, 8'h5a, 8'h5a, 0},
    '{ccpvs_off_ctrl, 8'h7f, 8'h1f, 0}, '{ccpvs_off_ctrl, 8'h00, 8'h00, 0},
    '{ccpvs_off_mask, 8'hff, 8'h01, 0}, '{ccpvs_off_status, 8'h01, 8'h00, 0},
    '{8'h18, 8'hff, 8'h00, 0}};
  // pwm rows: ctrl, low byte, high byte, high cycles per period
  ccpvs_row_t  pw [3] = '{'{8'h8f, 8'h10, 8'hfc, 8'd17},
    '{8'h9f, 8'h7f, 8'h04, 8'd18}, '{8'h8f, 8'h00, 8'h00, 8'd0}};
  // compare rows: ctrl byte, then unit output expected after a match
  logic [15:0] cm [3] = '{16'h8900, 16'h8201, 16'h8100};
  ccpvs_top i_ccpvs_top (.clk_in, .reset_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out,
    .pslverr_out, .timer_in, .time_base_in, .period_end_in, .sources_in,
    .converter_src_sel_in, .unit_out, .timer_clear_out,
    .converter_trigger_out, .irq_out);
  ccpvs_timer_model #(.period_cycles(per)) i_ccpvs_timer_model (.clk_in,
    .reset_in, .run_in(run), .load_in(load), .value_in(load_val),
    .timer_clear_in(timer_clear_out), .timer_out(timer_in),
    .time_base_out(time_base_in), .period_end_out(period_end_in));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until the edge that sees pready, one idle edge after
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= {24'h0, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd_v = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd_v, e);
  endtask
  task automatic tset(input logic [15:0] v);
    load <= 1'b1;
    load_val <= v;
    @(posedge clk_in);
    load <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic pulse(input int b);
    sources_in <= ccpvs_sources_t'(8'h01 << b);
    repeat (4) @(posedge clk_in);
    sources_in <= '0;
    repeat (6) @(posedge clk_in);
  endtask
  task automatic wait_pe();
    do @(posedge clk_in); while (period_end_in !== 1'b1);
  endtask
  task automatic cnt_high(output int h);
    h = 0;
    repeat (per) begin
      @(posedge clk_in);
      if (unit_out === 1'b1) h++;
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // generous ceiling: the whole run needs under two thousand cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (converter_trigger_out === 1'b1) conv_n <= conv_n + 1;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {psel_in, penable_in, pwrite_in, run, load} = 5'b0;
    {paddr_in, pwdata_in, load_val, sources_in} = '0;
    {miscompares, checks_done} = '0;
    pstrb_in = 4'hf;
    converter_src_sel_in = 1'b1;
    reset_in = 1'b1;
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    for (n = 0; n < 6; n++) rd(8'(4 * n), 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, {24'h0, rows[i].e});
    end
    $display("test registers done");
    for (n = 0; n < 8; n++) begin
      wr(ccpvs_off_ctrl, 8'h00);
      wr(ccpvs_off_cap, 8'(n));
      wr(ccpvs_off_status, 8'h01);
      wr(ccpvs_off_ctrl, 8'h85);
      tset(16'h1100);
      pulse((n + 1) % 8);
      rd(ccpvs_off_status, 32'h0);
      tset(16'hc3a0 + 16'(n));
      pulse(n);
      rd(ccpvs_off_low, 32'ha0 + 32'(n));
      rd(ccpvs_off_high, 32'hc3);
      chk(32'(irq_out), 32'h1);
    end
    chk(conv_n, 32'd8);
    wr(ccpvs_off_mask, 8'h00);
    chk(32'(irq_out), 32'h0);
    rd(ccpvs_off_status, 32'h1);
    wr(ccpvs_off_status, 8'h01);
    rd(ccpvs_off_status, 32'h0);
    wr(ccpvs_off_ctrl, 8'h00);
    wr(ccpvs_off_ctrl, 8'h84);
    tset(16'h0f0f);
    converter_src_sel_in <= 1'b0;
    sources_in <= ccpvs_sources_t'(8'h80);
    repeat (6) @(posedge clk_in);
    rd(ccpvs_off_status, 32'h0);
    sources_in <= '0;
    repeat (6) @(posedge clk_in);
    rd(ccpvs_off_status, 32'h1);
    rd(ccpvs_off_low, 32'h0f);
    wr(ccpvs_off_status, 8'h01);
    wr(ccpvs_off_ctrl, 8'h83);
    sources_in <= ccpvs_sources_t'(8'h80);
    repeat (6) @(posedge clk_in);
    rd(ccpvs_off_status, 32'h1);
    chk(conv_n, 32'd8);
    sources_in <= '0;
    converter_src_sel_in <= 1'b1;
    for (k = 0; k < 2; k++) begin
      wr(ccpvs_off_ctrl, 8'h00);
      wr(ccpvs_off_status, 8'h01);
      wr(ccpvs_off_ctrl, (k == 1) ? 8'h87 : 8'h86);
      for (n = 1; n <= ((k == 1) ? 16 : 4); n++) begin
        pulse(7);
        rd(ccpvs_off_status, 32'(n == ((k == 1) ? 16 : 4)));
      end
    end
    $display("test capture done");
    wr(ccpvs_off_ctrl, 8'h00);
    wr(ccpvs_off_low, 8'h23);
    wr(ccpvs_off_high, 8'h01);
    tset(16'h0023);
    wr(ccpvs_off_ctrl, 8'h88);
    chk(32'(unit_out), 32'h0);
    tset(16'h0124);
    repeat (2) @(posedge clk_in);
    chk(32'(unit_out), 32'h0);
    tset(16'h0123);
    repeat (2) @(posedge clk_in);
    chk(32'(unit_out), 32'h1);
    foreach (cm[i]) begin
      wr(ccpvs_off_ctrl, cm[i][15:8]);
      tset(16'h0120);
      tset(16'h0123);
      repeat (2) @(posedge clk_in);
      chk(32'(unit_out), 32'(cm[i][0]));
    end
    wr(ccpvs_off_ctrl, 8'h00);
    wr(ccpvs_off_ctrl, 8'h8b);
    tset(16'h0120);
    run <= 1'b1;
    n = 0;
    while (timer_clear_out !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    chk(32'(timer_clear_out), 32'h1);
    run <= 1'b0;
    $display("test compare done");
    foreach (pw[i]) begin
      wr(ccpvs_off_ctrl, 8'h00);
      wr(ccpvs_off_low, pw[i].d);
      wr(ccpvs_off_high, pw[i].e);
      wr(ccpvs_off_ctrl, pw[i].a);
      wait_pe();
      wait_pe();
      cnt_high(c);
      chk(32'(c), {24'h0, pw[i].n});
    end
    wr(ccpvs_off_ctrl, 8'h00);
    wr(ccpvs_off_low, 8'h10);
    wr(ccpvs_off_ctrl, 8'h8f);
    wait_pe();
    wait_pe();
    fork
      cnt_high(c);
      begin
        repeat (6) @(posedge clk_in);
        wr(ccpvs_off_low, 8'h02);
      end
    join
    chk(32'(c), 32'd17);
    cnt_high(c);
    chk(32'(c), 32'd3);
    $display("test pwm done");
    wr(ccpvs_off_cap, 8'h05);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    rd(ccpvs_off_cap, 32'h0);
    rd(ccpvs_off_ctrl, 32'h0);
    chk(32'(unit_out), 32'h0);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
